// File: logic/dmc_pkg.sv
package dmc_pkg;

  // Register word width
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 16;

  // Monitor register addresses
  localparam logic [15:0] ADDR_RUN_STATUS = 16'h002c;
  localparam logic [15:0] ADDR_RELAY_STATUS = 16'h002d;
  localparam logic [15:0] ADDR_DC_BUS = 16'h0031;
  localparam logic [15:0] ADDR_TORQUE = 16'h0032;
  localparam logic [15:0] ADDR_POWER = 16'h0033;
  localparam logic [15:0] ADDR_CPU_FW = 16'h003b;
  localparam logic [15:0] ADDR_FLASH_FW = 16'h003c;
  localparam logic [15:0] ADDR_LINK_ERR = 16'h003d;
  localparam logic [15:0] ADDR_RATING = 16'h003e;
  localparam logic [15:0] ADDR_CTRL_METHOD = 16'h003f;

  // Commit registers
  localparam logic [15:0] ADDR_COMMIT_PERSIST = 16'h0900;
  localparam logic [15:0] ADDR_COMMIT_VOLATILE = 16'h0910;
  localparam logic [15:0] COMMIT_VALUE = 16'h0000;

  // Directly effective speed reference
  localparam logic [15:0] ADDR_SPEED_REF = 16'h0002;

  // Fault trace and history words
  localparam logic [15:0] ADDR_FAULT_TRACE = 16'h0080;
  localparam logic [15:0] ADDR_FAULT_HIST = 16'h0090;
  localparam int unsigned HIST_DEPTH = 4;
  localparam logic [7:0] FAULT_CODE_MIN = 8'h01;
  localparam logic [7:0] FAULT_CODE_MAX = 8'h94;

  // Staged parameter window
  localparam logic [15:0] ADDR_PARAM_BASE = 16'h0100;
  localparam int unsigned PARAM_AW = 6;
  localparam int unsigned PARAM_DEPTH = 64;

  // Run status bit positions
  localparam int unsigned ST_LOW_FREQ = 4;
  localparam int unsigned ST_HIGH_FREQ = 5;
  localparam int unsigned ST_BLOCKED = 8;
  localparam int unsigned ST_REF_SRC = 9;
  localparam int unsigned ST_RUN_SRC = 10;

  // Link error detail bit positions
  localparam int unsigned LE_CRC = 0;
  localparam int unsigned LE_LENGTH = 1;
  localparam int unsigned LE_PARITY = 3;
  localparam int unsigned LE_OVERRUN = 4;
  localparam int unsigned LE_FRAMING = 5;
  localparam int unsigned LE_TIMEOUT = 6;

  // Error answer codes
  localparam logic [7:0] ERR_BAD_REG = 8'h02;
  localparam logic [7:0] ERR_WRITE_MODE = 8'h22;
  localparam logic [7:0] ERR_BUSY = 8'h24;
  localparam logic [7:0] ERR_NONE = 8'h00;

  // Firmware numbers, arbitrary values
  localparam logic [15:0] CPU_FW_NUMBER = 16'h0101;
  localparam logic [15:0] FLASH_FW_NUMBER = 16'h0202;

  // Commit sequencer states
  typedef enum logic [3:0] {
    CS_IDLE = 4'b0001,
    CS_FETCH = 4'b0010,
    CS_STORE = 4'b0100,
    CS_EEPROM = 4'b1000
  } dmc_commit_type;

endpackage : dmc_pkg

// File: logic/dmc_word_ram.sv
`timescale 1ns/1ps
// Simple dual port word memory with registered read data
module dmc_word_ram #(
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 16
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [DW-1:0] i_wr_data,
  // Read port
  input wire logic [AW-1:0] i_rd_addr,
  output logic [DW-1:0] o_rd_data
);

  // Storage array
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // Read data register
  logic [DW-1:0] rd_data_r;

  // Write side
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Read side, one cycle latency
  always_ff @(posedge i_clk) begin
    rd_data_r <= mem[i_rd_addr];
  end

  assign o_rd_data = rd_data_r;

endmodule : dmc_word_ram

// File: logic/dmc_regs.sv
`timescale 1ns/1ps
module dmc_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register request port
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic i_reg_bcast,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  // Register answer port
  output logic o_reg_ack,
  output logic o_reg_err,
  output logic [7:0] o_reg_err_code,
  output logic [15:0] o_reg_rdata,
  // Drive state inputs
  input wire logic [15:0] i_output_freq,
  input wire logic [15:0] i_speed_detect_level_param,
  input wire logic i_output_blocked,
  input wire logic i_ref_from_comm,
  input wire logic i_run_from_comm,
  input wire logic i_drive_running,
  input wire logic [15:0] i_status_other,
  input wire logic [2:0] i_relay_closed,
  input wire logic [15:0] i_dc_bus_voltage,
  input wire logic [15:0] i_torque,
  input wire logic [15:0] i_power,
  input wire logic [15:0] i_rating,
  input wire logic [15:0] i_ctrl_method,
  // Link error events and reset
  input wire logic i_err_crc,
  input wire logic i_err_length,
  input wire logic i_err_parity,
  input wire logic i_err_overrun,
  input wire logic i_err_framing,
  input wire logic i_err_timeout,
  input wire logic i_error_reset,
  // Fault events
  input wire logic i_fault_event,
  input wire logic [7:0] i_fault_code,
  // Working parameter read port
  input wire logic [5:0] i_param_addr,
  output logic [15:0] o_param_data,
  // Direct speed reference
  output logic [15:0] o_speed_ref,
  // EEPROM write port
  output logic o_eeprom_wr,
  output logic [5:0] o_eeprom_addr,
  output logic [15:0] o_eeprom_data,
  input wire logic i_eeprom_ready,
  // Commit progress
  output logic o_commit_busy,
  output logic o_commit_done
);

  // Run status word as assembled
  logic [15:0] run_status;
  // Sticky link error word
  logic [15:0] link_err_r;
  // Fault trace and history
  logic [7:0] fault_trace_r;
  logic [7:0] fault_hist_r [0:dmc_pkg::HIST_DEPTH-1];
  // Speed reference register
  logic [15:0] speed_ref_r;
  // Answer registers
  logic ack_r;
  logic err_r;
  logic [7:0] err_code_r;
  logic [15:0] rdata_r;
  logic param_rd_r;
  // Request decode
  logic req;
  logic param_hit;
  logic ro_hit;
  logic commit_hit;
  logic persist_hit;
  logic [5:0] param_idx;
  logic [15:0] ro_value;
  // Commit sequencer
  dmc_pkg::dmc_commit_type cstate_r;
  dmc_pkg::dmc_commit_type cstate_nxt;
  logic [5:0] cidx_r;
  logic persist_r;
  logic start_commit;
  logic done_r;
  logic eep_wr_r;
  logic [5:0] eep_addr_r;
  logic [15:0] eep_data_r;
  // Memory ports
  logic stage_wr;
  logic [15:0] stage_rdata;
  logic [5:0] work_rd_addr;
  logic [15:0] work_rdata;
  logic work_wr;

  // True for a legal fault code
  function automatic logic fault_code_ok(input logic [7:0] code);
    fault_code_ok = (code >= dmc_pkg::FAULT_CODE_MIN) && (code <= dmc_pkg::FAULT_CODE_MAX);
  endfunction : fault_code_ok

  // True for an address inside the staged parameter window
  function automatic logic in_param_window(input logic [15:0] addr);
    in_param_window = (addr >= dmc_pkg::ADDR_PARAM_BASE) &&
      (addr < dmc_pkg::ADDR_PARAM_BASE + 16'(dmc_pkg::PARAM_DEPTH));
  endfunction : in_param_window

  // Status word assembly; other bits pass from the drive
  always_comb begin
    run_status = i_status_other;
    run_status[dmc_pkg::ST_LOW_FREQ] = (i_output_freq <= i_speed_detect_level_param);
    run_status[dmc_pkg::ST_HIGH_FREQ] = (i_output_freq >= i_speed_detect_level_param);
    run_status[dmc_pkg::ST_BLOCKED] = i_output_blocked;
    run_status[dmc_pkg::ST_REF_SRC] = ~i_ref_from_comm;
    run_status[dmc_pkg::ST_RUN_SRC] = ~i_run_from_comm;
  end

  // Sticky link error flags; a new event beats the reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      link_err_r <= 16'h0000;
    end else begin
      if (i_error_reset) begin
        link_err_r <= 16'h0000;
      end
      if (i_err_crc) begin
        link_err_r[dmc_pkg::LE_CRC] <= 1'b1;
      end
      if (i_err_length) begin
        link_err_r[dmc_pkg::LE_LENGTH] <= 1'b1;
      end
      if (i_err_parity) begin
        link_err_r[dmc_pkg::LE_PARITY] <= 1'b1;
      end
      if (i_err_overrun) begin
        link_err_r[dmc_pkg::LE_OVERRUN] <= 1'b1;
      end
      if (i_err_framing) begin
        link_err_r[dmc_pkg::LE_FRAMING] <= 1'b1;
      end
      if (i_err_timeout) begin
        link_err_r[dmc_pkg::LE_TIMEOUT] <= 1'b1;
      end
    end
  end

  // Current fault capture; out-of-range codes are dropped
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fault_trace_r <= 8'h00;
    end else if (i_fault_event && fault_code_ok(i_fault_code)) begin
      fault_trace_r <= i_fault_code;
    end
  end

  // Fault history shift, newest at entry zero
  genvar gh;
  generate
    for (gh = 0; gh < dmc_pkg::HIST_DEPTH; gh++) begin : g_hist
      // Word shifted into this entry; the head takes the outgoing current fault
      logic [7:0] hist_src;
      if (gh == 0) begin : g_head
        assign hist_src = fault_trace_r;
      end else begin : g_tail
        assign hist_src = fault_hist_r[gh-1];
      end
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          fault_hist_r[gh] <= 8'h00;
        end else if (i_fault_event && fault_code_ok(i_fault_code)) begin
          fault_hist_r[gh] <= hist_src;
        end
      end
    end
  endgenerate

  // Request decode
  assign req = i_reg_rd | i_reg_wr;
  assign param_hit = in_param_window(i_reg_addr);
  assign param_idx = i_reg_addr[5:0];
  assign persist_hit = (i_reg_addr == dmc_pkg::ADDR_COMMIT_PERSIST);
  assign commit_hit = persist_hit || (i_reg_addr == dmc_pkg::ADDR_COMMIT_VOLATILE);

  // Read-only word selection; unused bits read zero
  always_comb begin
    ro_hit = 1'b1;
    ro_value = 16'h0000;
    if (i_reg_addr >= dmc_pkg::ADDR_FAULT_HIST &&
        i_reg_addr < dmc_pkg::ADDR_FAULT_HIST + 16'(dmc_pkg::HIST_DEPTH)) begin
      ro_value = {8'h00, fault_hist_r[i_reg_addr[1:0]]};
    end else begin
      unique case (i_reg_addr)
        dmc_pkg::ADDR_RUN_STATUS: ro_value = run_status;
        dmc_pkg::ADDR_RELAY_STATUS: ro_value = {13'h0000, i_relay_closed};
        dmc_pkg::ADDR_DC_BUS: ro_value = i_dc_bus_voltage;
        dmc_pkg::ADDR_TORQUE: ro_value = i_torque;
        dmc_pkg::ADDR_POWER: ro_value = i_power;
        dmc_pkg::ADDR_CPU_FW: ro_value = dmc_pkg::CPU_FW_NUMBER;
        dmc_pkg::ADDR_FLASH_FW: ro_value = dmc_pkg::FLASH_FW_NUMBER;
        dmc_pkg::ADDR_LINK_ERR: ro_value = link_err_r;
        dmc_pkg::ADDR_RATING: ro_value = i_rating;
        dmc_pkg::ADDR_CTRL_METHOD: ro_value = i_ctrl_method;
        dmc_pkg::ADDR_FAULT_TRACE: ro_value = {8'h00, fault_trace_r};
        default: ro_hit = 1'b0;
      endcase
    end
  end

  // Answer generation, one cycle after the request; broadcast writes get none
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      err_code_r <= dmc_pkg::ERR_NONE;
      rdata_r <= 16'h0000;
      param_rd_r <= 1'b0;
    end else begin
      ack_r <= req && !(i_reg_wr && i_reg_bcast);
      err_r <= 1'b0;
      err_code_r <= dmc_pkg::ERR_NONE;
      rdata_r <= 16'h0000;
      param_rd_r <= 1'b0;
      if (i_reg_rd) begin
        // Read side
        if (ro_hit) begin
          rdata_r <= ro_value;
        end else if (param_hit) begin
          param_rd_r <= 1'b1;
        end else if (i_reg_addr == dmc_pkg::ADDR_SPEED_REF) begin
          rdata_r <= speed_ref_r;
        end else begin
          err_r <= 1'b1;
          err_code_r <= dmc_pkg::ERR_BAD_REG;
        end
      end else if (i_reg_wr) begin
        // Write side
        if (i_reg_addr == dmc_pkg::ADDR_SPEED_REF) begin
          err_r <= 1'b0;
        end else if (param_hit || commit_hit) begin
          if (o_commit_busy) begin
            err_r <= 1'b1;
            err_code_r <= dmc_pkg::ERR_BUSY;
          end else if (commit_hit && i_drive_running) begin
            err_r <= 1'b1;
            err_code_r <= dmc_pkg::ERR_WRITE_MODE;
          end
        end else if (ro_hit) begin
          err_r <= 1'b1;
          err_code_r <= dmc_pkg::ERR_WRITE_MODE;
        end else begin
          err_r <= 1'b1;
          err_code_r <= dmc_pkg::ERR_BAD_REG;
        end
      end
    end
  end

  assign o_reg_ack = ack_r;
  assign o_reg_err = err_r;
  assign o_reg_err_code = err_code_r;
  assign o_reg_rdata = param_rd_r ? work_rdata : rdata_r;

  // Speed reference takes effect at once, broadcast or not
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      speed_ref_r <= 16'h0000;
    end else if (i_reg_wr && i_reg_addr == dmc_pkg::ADDR_SPEED_REF) begin
      speed_ref_r <= i_reg_wdata;
    end
  end

  assign o_speed_ref = speed_ref_r;

  // Staging write; blocked while a commit is copying
  assign stage_wr = i_reg_wr && !i_reg_bcast && param_hit && !o_commit_busy;

  // Commit start; only the value zero triggers it
  assign start_commit = i_reg_wr && !i_reg_bcast && commit_hit && !o_commit_busy &&
    !i_drive_running && (i_reg_wdata == dmc_pkg::COMMIT_VALUE);

  // Commit sequencer next state
  always_comb begin
    cstate_nxt = cstate_r;
    unique case (cstate_r)
      dmc_pkg::CS_IDLE: begin
        if (start_commit) begin
          cstate_nxt = dmc_pkg::CS_FETCH;
        end
      end
      dmc_pkg::CS_FETCH: cstate_nxt = dmc_pkg::CS_STORE;
      dmc_pkg::CS_STORE: begin
        if (persist_r) begin
          cstate_nxt = dmc_pkg::CS_EEPROM;
        end else if (cidx_r == 6'(dmc_pkg::PARAM_DEPTH - 1)) begin
          cstate_nxt = dmc_pkg::CS_IDLE;
        end else begin
          cstate_nxt = dmc_pkg::CS_FETCH;
        end
      end
      dmc_pkg::CS_EEPROM: begin
        if (i_eeprom_ready) begin
          if (cidx_r == 6'(dmc_pkg::PARAM_DEPTH - 1)) begin
            cstate_nxt = dmc_pkg::CS_IDLE;
          end else begin
            cstate_nxt = dmc_pkg::CS_FETCH;
          end
        end
      end
      default: cstate_nxt = dmc_pkg::CS_IDLE;
    endcase
  end

  // Commit state register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cstate_r <= dmc_pkg::CS_IDLE;
    end else begin
      cstate_r <= cstate_nxt;
    end
  end

  // Commit kind and word index
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      persist_r <= 1'b0;
      cidx_r <= 6'h00;
    end else if (start_commit) begin
      persist_r <= persist_hit;
      cidx_r <= 6'h00;
    end else if (cstate_r != dmc_pkg::CS_IDLE && cstate_nxt == dmc_pkg::CS_FETCH) begin
      cidx_r <= cidx_r + 6'h01;
    end
  end

  // Working copy written from staging in the store step
  assign work_wr = (cstate_r == dmc_pkg::CS_STORE);

  // EEPROM write strobe held until the EEPROM takes the word
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      eep_wr_r <= 1'b0;
      eep_addr_r <= 6'h00;
      eep_data_r <= 16'h0000;
    end else if (cstate_r == dmc_pkg::CS_STORE && persist_r) begin
      eep_wr_r <= 1'b1;
      eep_addr_r <= cidx_r;
      eep_data_r <= stage_rdata;
    end else if (cstate_r == dmc_pkg::CS_EEPROM && i_eeprom_ready) begin
      eep_wr_r <= 1'b0;
    end
  end

  assign o_eeprom_wr = eep_wr_r;
  assign o_eeprom_addr = eep_addr_r;
  assign o_eeprom_data = eep_data_r;

  // Done pulse on return to idle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (cstate_r != dmc_pkg::CS_IDLE) && (cstate_nxt == dmc_pkg::CS_IDLE);
    end
  end

  assign o_commit_done = done_r;
  assign o_commit_busy = (cstate_r != dmc_pkg::CS_IDLE);

  // Working copy read: bus reads win over the drive's port
  assign work_rd_addr = (i_reg_rd && param_hit) ? param_idx : i_param_addr;
  assign o_param_data = work_rdata;

  // Staged parameter area
  dmc_word_ram #(
    .AW(dmc_pkg::PARAM_AW),
    .DW(dmc_pkg::WORD_W)
  ) u_stage (
    .i_clk(i_clk),
    .i_wr_en(stage_wr),
    .i_wr_addr(param_idx),
    .i_wr_data(i_reg_wdata),
    .i_rd_addr(cidx_r),
    .o_rd_data(stage_rdata)
  );

  // Working parameter copy
  dmc_word_ram #(
    .AW(dmc_pkg::PARAM_AW),
    .DW(dmc_pkg::WORD_W)
  ) u_work (
    .i_clk(i_clk),
    .i_wr_en(work_wr),
    .i_wr_addr(cidx_r),
    .i_wr_data(stage_rdata),
    .i_rd_addr(work_rd_addr),
    .o_rd_data(work_rdata)
  );

endmodule : dmc_regs

// File: verif/dmc_regs_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the monitor and commit register bank
module dmc_regs_asserts (
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic i_reg_bcast,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic o_reg_ack,
  input wire logic o_reg_err,
  input wire logic [7:0] o_reg_err_code,
  input wire logic [15:0] o_reg_rdata,
  // Drive state
  input wire logic [15:0] i_output_freq,
  input wire logic [15:0] i_speed_detect_level_param,
  input wire logic i_output_blocked,
  input wire logic i_ref_from_comm,
  input wire logic i_run_from_comm,
  input wire logic [2:0] i_relay_closed,
  input wire logic i_drive_running,
  // Commit side
  input wire logic o_eeprom_wr,
  input wire logic [5:0] o_eeprom_addr,
  input wire logic [15:0] o_eeprom_data,
  input wire logic i_eeprom_ready,
  input wire logic o_commit_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [4:0] st_exp_r; // Status bits expected for a read taken now
  logic [2:0] relay_r; // Relay state at the request edge
  logic vol_r; // High while a volatile commit runs
  // Capture what the next answer must reflect
  always_ff @(posedge i_clk) begin
    st_exp_r <= {!i_run_from_comm, !i_ref_from_comm, i_output_blocked,
      i_output_freq >= i_speed_detect_level_param, i_output_freq <= i_speed_detect_level_param};
    relay_r <= i_relay_closed;
  end
  // Volatile commit from acceptance until the sequencer idles
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      vol_r <= 1'b0;
    end else if (i_reg_wr && !i_reg_bcast && i_reg_addr == dmc_pkg::ADDR_COMMIT_VOLATILE
      && !o_commit_busy
      && i_reg_wdata == 16'h0000 && !i_drive_running) begin
      vol_r <= 1'b1;
    end else if (!o_commit_busy) begin
      vol_r <= 1'b0;
    end
  end
  a_status_bits: assert property (i_reg_rd && i_reg_addr == dmc_pkg::ADDR_RUN_STATUS
    |=> o_reg_rdata[10:8] == st_exp_r[4:2] && o_reg_rdata[5:4] == st_exp_r[1:0])
    else $error("status bits disagree with drive state");
  a_relay_word: assert property (i_reg_rd && i_reg_addr == dmc_pkg::ADDR_RELAY_STATUS
    |=> o_reg_ack && o_reg_rdata == {13'h0000, relay_r})
    else $error("relay word wrong");
  a_link_unused: assert property (i_reg_rd && i_reg_addr == dmc_pkg::ADDR_LINK_ERR
    |=> o_reg_rdata[15:7] == 9'h000 && !o_reg_rdata[2])
    else $error("unused link error bits set");
  a_fault_byte: assert property (i_reg_rd && i_reg_addr == dmc_pkg::ADDR_FAULT_TRACE
    |=> o_reg_rdata[15:8] == 8'h00)
    else $error("fault code wider than a byte");
  a_commit_start: assert property (i_reg_wr && !i_reg_bcast && i_reg_wdata == 16'h0000
    && !o_commit_busy
    && !i_drive_running && (i_reg_addr == dmc_pkg::ADDR_COMMIT_VOLATILE
    || i_reg_addr == dmc_pkg::ADDR_COMMIT_PERSIST) |=> o_commit_busy)
    else $error("commit not started");
  a_eeprom_hold: assert property (o_eeprom_wr && !i_eeprom_ready
    |=> o_eeprom_wr && $stable(o_eeprom_addr) && $stable(o_eeprom_data))
    else $error("eeprom request dropped before accepted");
  a_volatile_ram: assert property (vol_r |-> !o_eeprom_wr)
    else $error("volatile commit wrote eeprom");
  a_commit_read: assert property (i_reg_rd && (i_reg_addr == 16'h0900 || i_reg_addr == 16'h0910)
    |=> o_reg_ack && o_reg_err && o_reg_err_code == 8'h02 && o_reg_rdata == 16'h0000)
    else $error("commit register read not refused");
  a_unmapped_read: assert property (i_reg_rd && i_reg_addr inside {[16'h002e:16'h0030],
    [16'h0034:16'h003a]} |=> o_reg_err && o_reg_err_code == 8'h02)
    else $error("unmapped read not refused");
  a_bcast_silent: assert property (i_reg_wr && i_reg_bcast |=> !o_reg_ack)
    else $error("broadcast write answered");
endmodule : dmc_regs_asserts

bind dmc_regs dmc_regs_asserts chk_u (.*);

// File: verif/dmc_eeprom_model.sv
`timescale 1ns/1ps
// Behavioural EEPROM taking one word per handshake after a set delay
module dmc_eeprom_model (
  // Clock and write request
  input wire logic i_clk,
  input wire logic i_wr,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_data,
  // Cycles waited before each acceptance
  input wire logic [3:0] i_delay,
  output logic o_ready
);
  logic [15:0] mem [64]; // Stored words
  int writes = 0; // Words taken
  logic [3:0] wait_r = 4'h0; // Cycles waited on this request
  initial o_ready = 1'b0;
  // Store on the handshake, else count up to the delay then offer ready
  always @(posedge i_clk) begin
    if (i_wr && o_ready) begin
      mem[i_addr] <= i_data;
      writes <= writes + 1;
      o_ready <= 1'b0;
      wait_r <= 4'h0;
    end else if (i_wr && wait_r >= i_delay) begin
      o_ready <= 1'b1;
    end else if (i_wr) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : dmc_eeprom_model

// File: verif/tb_dmc_regs.sv
`timescale 1ns/1ps
// Register-level bench of the monitor and commit bank
module tb_dmc_regs;
  // Design inputs and the EEPROM model delay, all set at time zero
  logic i_clk = 1'b0, i_reset = 1'b1, i_reg_rd = 1'b0, i_reg_wr = 1'b0, i_reg_bcast = 1'b0;
  logic [15:0] i_reg_addr = 16'h0000, i_reg_wdata = 16'h0000, i_output_freq = 16'h0000;
  logic [15:0] i_speed_detect_level_param = 16'h0100, i_status_other = 16'h0000;
  logic i_output_blocked = 1'b1, i_ref_from_comm = 1'b0, i_run_from_comm = 1'b1;
  logic i_drive_running = 1'b0, i_error_reset = 1'b0, i_fault_event = 1'b0;
  logic [2:0] i_relay_closed = 3'b101;
  logic [15:0] i_dc_bus_voltage = 16'h1000, i_torque = 16'h1001, i_power = 16'h1002;
  logic [15:0] i_rating = 16'h1003, i_ctrl_method = 16'h1004;
  logic i_err_crc = 1'b0, i_err_length = 1'b0, i_err_parity = 1'b0;
  logic i_err_overrun = 1'b0, i_err_framing = 1'b0, i_err_timeout = 1'b0;
  logic [7:0] i_fault_code = 8'h00;
  logic [5:0] i_param_addr = 6'h05;
  logic [3:0] ee_delay = 4'h3;
  // Design outputs, plus the EEPROM model's ready into the design
  logic o_reg_ack, o_reg_err, o_eeprom_wr, i_eeprom_ready, o_commit_busy, o_commit_done;
  logic [7:0] o_reg_err_code;
  logic [15:0] o_reg_rdata, o_param_data, o_speed_ref, o_eeprom_data;
  logic [5:0] o_eeprom_addr;
  int miscompares = 0;
  int checks_done = 0;
  logic [15:0] exp;
  logic [15:0] mon [5] = '{16'h0031, 16'h0032, 16'h0033, 16'h003e, 16'h003f};
  logic [7:0] fc [4] = '{8'h94, 8'h00, 8'h95, 8'h01};
  dmc_regs dut_u (.*);
  dmc_eeprom_model ee_u (.i_clk(i_clk), .i_wr(o_eeprom_wr), .i_addr(o_eeprom_addr),
    .i_data(o_eeprom_data), .i_delay(ee_delay), .o_ready(i_eeprom_ready));
  // Clock
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    checks_done++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  // One access; a missing answer reads as dead/ee
  task automatic acc(input logic wr, input logic bc, input logic [15:0] addr,
    input logic [15:0] data, input logic [15:0] exp_rdata, input logic [7:0] exp_code);
    logic [15:0] rdata;
    logic [7:0] code;
    rdata = 16'hdead;
    code = 8'hee;
    @(negedge i_clk);
    {i_reg_rd, i_reg_wr, i_reg_bcast, i_reg_addr, i_reg_wdata} = {!wr, wr, bc, addr, data};
    @(negedge i_clk);
    {i_reg_rd, i_reg_wr, i_reg_bcast} = 3'b000;
    for (int n = 0; n < 3; n++) begin
      if (o_reg_ack === 1'b1) begin
        rdata = o_reg_rdata;
        code = o_reg_err_code;
        break;
      end
      @(negedge i_clk);
    end
    check(rdata, exp_rdata);
    check({8'h00, code}, {8'h00, exp_code});
  endtask : acc
  // Pulse error reset and link error events for one cycle
  task automatic evt(input logic [6:0] m);
    @(negedge i_clk);
    {i_error_reset, i_err_timeout, i_err_framing, i_err_overrun, i_err_parity, i_err_length,
      i_err_crc} = m;
    @(negedge i_clk);
    {i_error_reset, i_err_timeout, i_err_framing, i_err_overrun, i_err_parity, i_err_length,
      i_err_crc} = 7'h00;
  endtask : evt
  // Wait for the commit done pulse
  task automatic wait_done();
    for (int n = 0; n < 3000 && o_commit_done !== 1'b1; n++) @(negedge i_clk);
    check({15'h0000, o_commit_done}, 16'h0001);
  endtask : wait_done
  // Closing verdict
  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // Watchdog
  initial begin
    #120000;
    miscompares++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge i_clk);
    i_reset = 1'b0;
    for (int k = 0; k < 3; k++) begin
      i_output_freq = 16'h00ff + 16'(k);
      exp = 16'h0300;
      exp[4] = (k < 2);
      exp[5] = (k > 0);
      acc(1'b0, 1'b0, dmc_pkg::ADDR_RUN_STATUS, 16'h0000, exp, 8'h00);
    end
    {i_status_other, i_output_blocked, i_ref_from_comm, i_run_from_comm} = {16'hffff, 3'b010};
    acc(1'b0, 1'b0, dmc_pkg::ADDR_RUN_STATUS, 16'h0000, 16'hfcef, 8'h00);
    acc(1'b0, 1'b0, 16'h002d, 16'h0000, 16'h0005, 8'h00);
    foreach (mon[k]) acc(1'b0, 1'b0, mon[k], 16'h0000, 16'h1000 + 16'(k), 8'h00);
    acc(1'b0, 1'b0, 16'h003b, 16'h0000, dmc_pkg::CPU_FW_NUMBER, 8'h00);
    acc(1'b0, 1'b0, 16'h0030, 16'h0000, 16'h0000, 8'h02);
    acc(1'b1, 1'b0, 16'h002c, 16'h1111, 16'h0000, 8'h22);
    evt(7'h25);
    acc(1'b0, 1'b0, 16'h003d, 16'h0000, 16'h0049, 8'h00);
    evt(7'h1a);
    acc(1'b0, 1'b0, 16'h003d, 16'h0000, 16'h007b, 8'h00);
    evt(7'h41);
    acc(1'b0, 1'b0, 16'h003d, 16'h0000, 16'h0001, 8'h00);
    evt(7'h40);
    acc(1'b0, 1'b0, 16'h003d, 16'h0000, 16'h0000, 8'h00);
    foreach (fc[k]) begin
      @(negedge i_clk);
      {i_fault_event, i_fault_code} = {1'b1, fc[k]};
      @(negedge i_clk);
      i_fault_event = 1'b0;
    end
    acc(1'b0, 1'b0, 16'h0080, 16'h0000, 16'h0001, 8'h00);
    acc(1'b0, 1'b0, 16'h0090, 16'h0000, 16'h0094, 8'h00);
    acc(1'b1, 1'b0, 16'h0002, 16'h0abc, 16'h0000, 8'h00);
    check(o_speed_ref, 16'h0abc);
    acc(1'b1, 1'b1, 16'h0002, 16'h0def, 16'hdead, 8'hee);
    check(o_speed_ref, 16'h0def);
    acc(1'b0, 1'b0, 16'h0900, 16'h0000, 16'h0000, 8'h02);
    acc(1'b0, 1'b0, 16'h0910, 16'h0000, 16'h0000, 8'h02);
    acc(1'b1, 1'b0, 16'h0105, 16'h1234, 16'h0000, 8'h00);
    acc(1'b1, 1'b0, 16'h0910, 16'h0001, 16'h0000, 8'h00);
    check({15'h0000, o_commit_busy}, 16'h0000);
    acc(1'b1, 1'b0, 16'h0910, 16'h0000, 16'h0000, 8'h00);
    acc(1'b1, 1'b0, 16'h0105, 16'h5555, 16'h0000, 8'h24);
    wait_done();
    acc(1'b0, 1'b0, 16'h0105, 16'h0000, 16'h1234, 8'h00);
    check(o_param_data, 16'h1234);
    check(16'(ee_u.writes), 16'h0000);
    acc(1'b1, 1'b0, 16'h0105, 16'h5678, 16'h0000, 8'h00);
    acc(1'b0, 1'b0, 16'h0105, 16'h0000, 16'h1234, 8'h00);
    i_drive_running = 1'b1;
    acc(1'b1, 1'b0, 16'h0900, 16'h0000, 16'h0000, 8'h22);
    i_drive_running = 1'b0;
    // Single persistent commit in the whole run to spare the EEPROM
    acc(1'b1, 1'b0, 16'h0900, 16'h0000, 16'h0000, 8'h00);
    wait_done();
    acc(1'b0, 1'b0, 16'h0105, 16'h0000, 16'h5678, 8'h00);
    check(ee_u.mem[5], 16'h5678);
    check(16'(ee_u.writes), 16'h0040);
    give_verdict();
  end
endmodule : tb_dmc_regs
